// ---- logic/nv_program_erase_control.v ----
`timescale 1ns/1ps
`default_nettype none
`include "nv_control_map.vh"
module nv_program_erase_control #(
   parameter integer CYCLE_CLKS = `NV_CYCLE_CLKS, // 2 ms at 250 MHz
   parameter integer EE_WORDS   = `NV_EE_WORDS    // EEPROM depth in words
) (
   input  wire        ref_clk,       // core clock, 250 MHz
   input  wire        rst_n,         // sync reset, active low
   input  wire        powerOn,       // high for a power-up reset, low for master clear or watchdog
   input  wire        sfrWrite,      // register write strobe
   input  wire [15:0] sfrAddr,       // register byte address
   input  wire [15:0] sfrWdata,      // register write data
   input  wire        sfrRead,       // register read strobe
   output reg  [15:0] sfrRdata,      // register read data
   input  wire        tableStore,    // table_store_low to latch
   input  wire        tableRead,     // table_read_low request
   input  wire [23:0] tableAddr,     // table effective address
   input  wire [15:0] tableWdata,    // table_store_low data
   output reg  [15:0] tableRdata,    // table_read_low data
   input  wire        doneFlagClear, // software clears nv_done_irq_flag
   output reg         doneFlag,      // nv_done_irq_flag
   output wire        cpuStall,      // stall processor during flash cycle
   output reg         flashStart,    // pulse: launch flash row operation
   output reg  [23:0] flashRowAddr,  // flash row base address
   output reg         flashErase     // flash operation is erase
);
   // ----------------------------------------
   // registers and storage
   // ----------------------------------------
   reg [15:0] addrLow_reg;
   reg [7:0]  addrHigh_reg;
   reg        go_reg;
   reg        unlock_reg;
   reg        abort_reg;
   reg        timed_reg;
   reg [6:0]  opSel_reg;
   reg        busyIsFlash_reg;
   reg [15:0] eeMem [0:EE_WORDS-1];
   reg [15:0] eeLatch [0:`NV_EE_BLOCK_WORDS-1];

   wire        armed;
   wire        busy;
   wire        done;
   wire        wrCtl   = sfrWrite && sfrAddr == `NV_CONTROL_OFS;
   wire        wrKey   = sfrWrite && sfrAddr == `NV_UNLOCK_KEY_OFS;
   wire [23:0] target  = {addrHigh_reg, addrLow_reg};
   wire        isEe    = opSel_reg[`NV_OP_EEPROM_BIT];
   wire        isErase = opSel_reg[`NV_OP_ERASE_BIT];
   wire [11:0] eeIndex = target[12:1];
   wire        inEe    = target >= `NV_EE_BASE && target <= `NV_EE_LAST;
   wire        tabInEe = tableAddr >= `NV_EE_BASE && tableAddr <= `NV_EE_LAST;

   // go may be set only with unlock already stored and the key pair armed
   wire launch = wrCtl && sfrWdata[`NV_CTL_GO_BIT] && !go_reg && unlock_reg && armed;

   // ----------------------------------------
   // key sequence and cycle timer
   // ----------------------------------------
   nv_key_arm keyArm (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .regWrite (sfrWrite),
      .keyWrite (wrKey),
      .keyData  (sfrWdata[7:0]),
      .armed    (armed)
   );

   nv_cycle_timer #(.CYCLE_CLKS(CYCLE_CLKS)) cycleTimer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .start   (launch),
      .busy    (busy),
      .done    (done)
   );

   // flash stalls the core; EEPROM cycles let it run on
   assign cpuStall = busy && busyIsFlash_reg;

   // ----------------------------------------
   // control register
   // ----------------------------------------
   // a reset cuts any running cycle, so the abort flag records a non-power reset mid-cycle
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         go_reg          <= 1'b0;
         unlock_reg      <= 1'b0;
         timed_reg       <= 1'b0;
         opSel_reg       <= 7'h00;
         busyIsFlash_reg <= 1'b0;
         abort_reg       <= (go_reg && !powerOn) ? 1'b1 : (powerOn ? 1'b0 : abort_reg);
      end else begin
         if (wrCtl) begin
            unlock_reg <= sfrWdata[`NV_CTL_UNLOCK_BIT];
            abort_reg  <= sfrWdata[`NV_CTL_ABORT_BIT];
            timed_reg  <= sfrWdata[`NV_CTL_TIMED_BIT];
            opSel_reg  <= sfrWdata[`NV_CTL_OPSEL_MSB:`NV_CTL_OPSEL_LSB];
         end
         // software cannot clear go; only completion or a reset does
         if (launch) begin
            go_reg          <= 1'b1;
            busyIsFlash_reg <= !sfrWdata[`NV_OP_EEPROM_BIT];
         end else if (done) begin
            go_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // address registers
   // ----------------------------------------
   // not reset, so the low address survives an aborting reset; table accesses capture it
   always @(posedge ref_clk) begin
      if (sfrWrite && sfrAddr == `NV_ADDRESS_LOW_OFS) begin
         addrLow_reg <= sfrWdata;
      end else if (tableStore || tableRead) begin
         addrLow_reg <= tableAddr[15:0];
      end
      if (sfrWrite && sfrAddr == `NV_ADDRESS_HIGH_OFS) begin
         addrHigh_reg <= sfrWdata[7:0];
      end else if (tableStore || tableRead) begin
         addrHigh_reg <= tableAddr[23:16];
      end
   end

   // ----------------------------------------
   // done flag
   // ----------------------------------------
   // completion wins over a clear in the same cycle
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         doneFlag <= 1'b0;
      end else if (done) begin
         doneFlag <= 1'b1;
      end else if (doneFlagClear) begin
         doneFlag <= 1'b0;
      end
   end

   // ----------------------------------------
   // EEPROM latches and array
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `NV_EE_BLOCK_WORDS; gi = gi + 1) begin : latchGen
         // latch picked by the low address bits of the table store
         always @(posedge ref_clk) begin
            if (tableStore && tabInEe && tableAddr[4:1] == gi) begin
               eeLatch[gi] <= tableWdata;
            end
         end
      end
   endgenerate

   // the array changes at cycle end; word or 16-word block, erase to all ones
   always @(posedge ref_clk) begin : eeUpdate
      integer k;
      if (done && !busyIsFlash_reg && isEe && inEe) begin
         for (k = 0; k < `NV_EE_BLOCK_WORDS; k = k + 1) begin
            if (opSel_reg[1:0] == `NV_OP_EE_BLOCK) begin
               eeMem[{eeIndex[11:4], k[3:0]}] <= isErase ? 16'hFFFF : eeLatch[k];
            end else if (k[3:0] == eeIndex[3:0]) begin
               eeMem[eeIndex] <= isErase ? 16'hFFFF : eeLatch[k];
            end
         end
      end
   end

   // read returns the addressed word; data during a running cycle is unspecified
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         tableRdata <= 16'h0000;
      end else if (tableRead) begin
         tableRdata <= tabInEe ? eeMem[tableAddr[12:1]] : 16'h0000;
      end
   end

   // ----------------------------------------
   // flash row request
   // ----------------------------------------
   // the row base drops the in-row bits so a whole row of 32 is always acted on
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         flashStart   <= 1'b0;
         flashRowAddr <= 24'h000000;
         flashErase   <= 1'b0;
      end else begin
         flashStart <= launch && !sfrWdata[`NV_OP_EEPROM_BIT];
         if (launch) begin
            flashRowAddr <= {target[23:6], 6'h00};
            flashErase   <= sfrWdata[`NV_OP_ERASE_BIT];
         end
      end
   end

   // ----------------------------------------
   // register read
   // ----------------------------------------
   // key register is write-only and reads zero, as do unmapped addresses
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         sfrRdata <= 16'h0000;
      end else if (sfrRead) begin
         if (sfrAddr == `NV_CONTROL_OFS) begin
            sfrRdata <= {go_reg, unlock_reg, abort_reg, 4'h0, timed_reg, 1'b0, opSel_reg};
         end else if (sfrAddr == `NV_ADDRESS_LOW_OFS) begin
            sfrRdata <= addrLow_reg;
         end else if (sfrAddr == `NV_ADDRESS_HIGH_OFS) begin
            sfrRdata <= {8'h00, addrHigh_reg};
         end else begin
            sfrRdata <= 16'h0000;
         end
      end
   end
endmodule
`default_nettype wire

// ---- logic/nv_control_map.vh ----
`ifndef NV_CONTROL_MAP_VH
`define NV_CONTROL_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define NV_ADDRESS_LOW_OFS   16'h0762
`define NV_ADDRESS_HIGH_OFS  16'h0764
`define NV_CONTROL_OFS       16'h0920
`define NV_UNLOCK_KEY_OFS    16'h9920
// ----------------------------------------
// control register fields
// ----------------------------------------
`define NV_CTL_GO_BIT        15
`define NV_CTL_UNLOCK_BIT    14
`define NV_CTL_ABORT_BIT     13
`define NV_CTL_TIMED_BIT     8
`define NV_CTL_OPSEL_MSB     6
`define NV_CTL_OPSEL_LSB     0
`define NV_CTL_RESET         16'h0000
`define NV_CTL_WMASK         16'h417F
// operation_select codes: bit 6 erase, bit 2 data EEPROM, low bits word or block
`define NV_OP_ERASE_BIT      6
`define NV_OP_EEPROM_BIT     2
`define NV_OP_EE_WORD        2'h0
`define NV_OP_EE_BLOCK       2'h1
// ----------------------------------------
// keys and memory map
// ----------------------------------------
`define NV_KEY_FIRST         8'h55
`define NV_KEY_SECOND        8'hAA
`define NV_EE_BASE           24'h7FF000
`define NV_EE_LAST           24'h7FFFFE
`define NV_EE_WORDS          4096
`define NV_EE_BLOCK_WORDS    16
`define NV_FLASH_ROW_WORDS   32
// ----------------------------------------
// timing
// ----------------------------------------
`define NV_CLK_MHZ           250
`define NV_CYCLE_US          2000
`define NV_CYCLE_CLKS        (`NV_CYCLE_US * `NV_CLK_MHZ)
`endif

// ---- logic/nv_key_arm.v ----
`timescale 1ns/1ps
`default_nettype none
`include "nv_control_map.vh"
module nv_key_arm (
   input  wire        ref_clk,  // core clock
   input  wire        rst_n,    // sync reset, active low
   input  wire        regWrite, // any register write this cycle
   input  wire        keyWrite, // write aimed at the key register
   input  wire [7:0]  keyData,  // key byte written
   output wire        armed     // key pair seen, go may be set
);
   // ----------------------------------------
   // two-step key tracker
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'h1, ST_HALF = 3'h2, ST_ARMED = 3'h4;
   reg [2:0] state_reg;
   reg [2:0] state_next;

   // any write between keys other than a repeated first key drops back to idle, including the go write itself
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (keyWrite && keyData == `NV_KEY_FIRST) state_next = ST_HALF;
         end
         ST_HALF: begin
            if (keyWrite && keyData == `NV_KEY_SECOND) state_next = ST_ARMED;
            else if (regWrite) state_next = (keyWrite && keyData == `NV_KEY_FIRST) ? ST_HALF : ST_IDLE;
         end
         ST_ARMED: begin
            if (regWrite) state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign armed = (state_reg == ST_ARMED);
endmodule
`default_nettype wire

// ---- logic/nv_cycle_timer.v ----
`timescale 1ns/1ps
`default_nettype none
module nv_cycle_timer #(
   parameter integer CYCLE_CLKS = 500000 // cycles in one 2 ms cycle
) (
   input  wire ref_clk, // core clock
   input  wire rst_n,   // sync reset, active low
   input  wire start,   // one-cycle pulse to launch
   output wire busy,    // cycle running
   output wire done     // one-cycle pulse at end
);
   // ----------------------------------------
   // down counter
   // ----------------------------------------
   reg [31:0] count_reg;

   // fixed nominal duration; real silicon varies with voltage and temperature
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         count_reg <= 32'h00000000;
      end else if (start && count_reg == 32'h00000000) begin
         count_reg <= CYCLE_CLKS;
      end else if (count_reg != 32'h00000000) begin
         count_reg <= count_reg - 32'h00000001;
      end
   end

   assign busy = (count_reg != 32'h00000000);
   assign done = (count_reg == 32'h00000001);
endmodule
`default_nettype wire

// ---- test/nv_program_erase_control_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module nv_program_erase_control_props #(
   parameter integer CYCLE_CLKS = 20,  // timed cycle length
   parameter integer EE_WORDS   = 4096 // EEPROM depth
) (
   input wire logic        ref_clk,       // core clock
   input wire logic        rst_n,         // sync reset
   input wire logic        sfrWrite,      // register write
   input wire logic [15:0] sfrAddr,       // register address
   input wire logic [15:0] sfrWdata,      // write data
   input wire logic [15:0] sfrRdata,      // read data
   input wire logic        doneFlag,      // done flag
   input wire logic        doneFlagClear, // done flag clear
   input wire logic        cpuStall,      // flash stall
   input wire logic        flashStart,    // flash launch
   input wire logic [23:0] flashRowAddr   // flash row base
);
// ----------------------------------------
// key tracking
// ----------------------------------------
wire logic keyWr = sfrWrite && sfrAddr == 16'h9920;
wire logic goWr  = sfrWrite && sfrAddr == 16'h0920 && sfrWdata[15];
logic        prevKeyA;
logic        armedSeen;
logic        startOk;
logic [15:0] stallCnt;
// only write strobes move the history, so idle gaps between keys are legal
always @(posedge ref_clk) begin
   if (!rst_n) begin
      prevKeyA  <= 1'b0;
      armedSeen <= 1'b0;
      startOk   <= 1'b0;
   end else if (sfrWrite) begin
      prevKeyA  <= keyWr && sfrWdata[7:0] == 8'h55;
      armedSeen <= prevKeyA && keyWr && sfrWdata[7:0] == 8'hAA;
      startOk   <= armedSeen && goWr;
   end
end
// stall length, cleared between cycles
always @(posedge ref_clk) begin
   if (!rst_n || !cpuStall) begin
      stallCnt <= 16'h0000;
   end else begin
      stallCnt <= stallCnt + 16'h0001;
   end
end
// ----------------------------------------
// properties
// ----------------------------------------
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!rst_n);
sequence stallRun;
   cpuStall [*8];
endsequence
AST_RST_QUIET: assert property ($rose(rst_n) |-> !doneFlag && !cpuStall && !flashStart && sfrRdata == 16'h0000)
   else $error("outputs not quiet after reset");
AST_START_NEEDS_KEYS: assert property (flashStart |-> startOk)
   else $error("flash launched without key pair before go");
AST_START_PULSE: assert property (flashStart |=> !flashStart)
   else $error("flash launch longer than one cycle");
AST_STALL_WITH_START: assert property (flashStart |-> cpuStall)
   else $error("no stall at flash launch");
AST_STALL_HOLD: assert property ($rose(cpuStall) |-> stallRun)
   else $error("stall dropped early");
AST_STALL_BOUND: assert property (cpuStall |-> stallCnt < CYCLE_CLKS + 2)
   else $error("stall outlasts the timed cycle");
AST_DONE_AT_END: assert property ($fell(cpuStall) && $past(rst_n) |-> doneFlag)
   else $error("done flag not set at end of flash cycle");
AST_DONE_STICKY: assert property (doneFlag && !doneFlagClear |=> doneFlag)
   else $error("done flag cleared by hardware");
AST_ROW_ALIGN: assert property (flashStart |-> flashRowAddr[5:0] == 6'h00)
   else $error("flash row base not aligned");
AST_EE_NO_STALL: assert property (goWr && sfrWdata[2] && !cpuStall |=> !cpuStall [*2])
   else $error("EEPROM cycle stalled the processor");
endmodule
bind nv_program_erase_control nv_program_erase_control_props #(
   .CYCLE_CLKS(CYCLE_CLKS),
   .EE_WORDS  (EE_WORDS)
) props_inst (.ref_clk, .rst_n, .sfrWrite, .sfrAddr, .sfrWdata, .sfrRdata, .doneFlag,
   .doneFlagClear, .cpuStall, .flashStart, .flashRowAddr);
`default_nettype wire

// ---- test/nv_program_erase_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module nv_program_erase_control_tb;
localparam integer      CYC = 20;
localparam logic [15:0] CTL = 16'h0920;
localparam logic [15:0] KEY = 16'h9920;
localparam logic [15:0] ADL = 16'h0762;
localparam logic [15:0] ADH = 16'h0764;
logic        ref_clk, rst_n, powerOn, sfrWrite, sfrRead, tableStore, tableRead, doneFlagClear;
logic        doneFlag, cpuStall, flashStart, flashErase;
logic [15:0] sfrAddr, sfrWdata, sfrRdata, tableWdata, tableRdata, v;
logic [23:0] tableAddr, flashRowAddr;
integer      num_errors, cmp_count, i, t;
integer      cyc = 0;
nv_program_erase_control #(.CYCLE_CLKS(CYC)) nv_program_erase_control_inst (.ref_clk, .rst_n,
   .powerOn, .sfrWrite, .sfrAddr, .sfrWdata, .sfrRead, .sfrRdata, .tableStore, .tableRead,
   .tableAddr, .tableWdata, .tableRdata, .doneFlagClear, .doneFlag, .cpuStall, .flashStart,
   .flashRowAddr, .flashErase);
// ----------------------------------------
// clock, timeout and access tasks
// ----------------------------------------
initial begin
   ref_clk = 1'b0;
   forever #2 ref_clk = ~ref_clk;
end
// a hang shows up as a stuck poll loop; cut it well past the planned run
always @(posedge ref_clk) begin
   cyc <= cyc + 1;
   if (cyc == 4000) begin
      num_errors = num_errors + 1;
      end_of_test;
   end
end
task automatic tick;
   @(posedge ref_clk);
   #1;
endtask
task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
   cmp_count = cmp_count + 1;
   if (g !== e) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
   end
endtask
// strobes drop for a full cycle so no signal is set twice in one step
task automatic regWrite(input logic [15:0] a, input logic [15:0] d);
   sfrAddr = a;
   sfrWdata = d;
   sfrWrite = 1'b1;
   tick;
   sfrWrite = 1'b0;
   tick;
endtask
task automatic regRead(input logic [15:0] a);
   sfrAddr = a;
   sfrRead = 1'b1;
   tick;
   sfrRead = 1'b0;
   tick;
   v = sfrRdata;
endtask
task automatic tblStore(input logic [23:0] a, input logic [15:0] d);
   tableAddr = a;
   tableWdata = d;
   tableStore = 1'b1;
   tick;
   tableStore = 1'b0;
   tick;
endtask
task automatic tblCheck(input logic [23:0] a, input logic [15:0] e);
   tableAddr = a;
   tableRead = 1'b1;
   tick;
   tableRead = 1'b0;
   tick;
   chk("table", {8'h00, e}, {8'h00, tableRdata});
endtask
task automatic startCycle(input logic [15:0] c);
   regWrite(CTL, c);
   regWrite(KEY, 16'h0055);
   regWrite(KEY, 16'h00AA);
   regWrite(CTL, c | 16'h8000);
endtask
task automatic lenCheck(input integer t0);
   chk("cycleLen", 24'h000001, {23'h000000, (cyc - t0 >= CYC + 5) && (cyc - t0 <= CYC + 12)});
endtask
// poll go until the running cycle ends; nothing else is started meanwhile
task automatic waitEnd;
   for (i = 0; i < 100; i = i + 1) begin
      regRead(CTL);
      if (v[15] === 1'b0) break;
   end
   lenCheck(t);
endtask
task automatic eeOp(input logic [15:0] c);
   t = cyc;
   startCycle(c);
   waitEnd;
endtask
task automatic reset(input logic po);
   powerOn = po;
   rst_n = 1'b0;
   repeat (8) tick;
   rst_n = 1'b1;
endtask
task automatic end_of_test;
   $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
   if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
   end else begin
      $display("Errors were found");
   end
   $finish;
endtask
// ----------------------------------------
// test sequence
// ----------------------------------------
initial begin
   {rst_n, sfrWrite, sfrRead, tableStore, tableRead, doneFlagClear} = 6'h00;
   powerOn = 1'b1;
   {sfrAddr, sfrWdata, tableWdata, tableAddr} = 72'h0;
   num_errors = 0;
   cmp_count = 0;
   reset(1'b1);
   regRead(CTL);
   chk("ctlReset", 24'h000000, {8'h00, v});
   regRead(KEY);
   chk("keyRead", 24'h000000, {8'h00, v});
   // go refused: with unlock in the same write, keys swapped, keys split
   regWrite(CTL, 16'hC044);
   regRead(CTL);
   chk("ctlGo", 24'h004044, {8'h00, v});
   regWrite(KEY, 16'h00AA);
   regWrite(KEY, 16'h0055);
   regWrite(CTL, 16'hC044);
   regRead(CTL);
   chk("ctlGo", 24'h004044, {8'h00, v});
   regWrite(KEY, 16'h0055);
   regWrite(ADL, 16'hFFFE);
   regWrite(KEY, 16'h00AA);
   regWrite(CTL, 16'hC044);
   regRead(CTL);
   chk("ctlGo", 24'h004044, {8'h00, v});
   // word erase then program at the top EEPROM word
   regWrite(ADH, 16'h007F);
   eeOp(16'h4044);
   tblCheck(24'h7FFFFE, 16'hFFFF);
   chk("done", 24'h000001, {23'h000000, doneFlag});
   doneFlagClear = 1'b1;
   tick;
   doneFlagClear = 1'b0;
   chk("done", 24'h000000, {23'h000000, doneFlag});
   tblStore(24'h7FFFFE, 16'h1234);
   t = cyc;
   startCycle(16'h4004);
   regWrite(CTL, 16'h4004);
   regRead(CTL);
   chk("ctlRun", 24'h00C004, {8'h00, v});
   waitEnd;
   tblCheck(24'h7FFFFE, 16'h1234);
   tblCheck(24'h7FEFFE, 16'h0000);
   // block erase then block program of sixteen words
   regWrite(ADL, 16'hF020);
   eeOp(16'h4045);
   tblCheck(24'h7FF03E, 16'hFFFF);
   for (i = 0; i < 16; i = i + 1) tblStore(24'h7FF020 + 2 * i, 16'hA500 + i);
   eeOp(16'h4005);
   for (i = 0; i < 16; i = i + 1) tblCheck(24'h7FF020 + 2 * i, 16'hA500 + i);
   // flash row erase stalls the processor for the whole cycle
   regWrite(ADH, 16'h0001);
   regWrite(ADL, 16'h1234);
   t = cyc;
   startCycle(16'h4041);
   chk("stall", 24'h000001, {23'h000000, cpuStall});
   chk("rowAddr", 24'h011200, flashRowAddr);
   chk("erase", 24'h000001, {23'h000000, flashErase});
   for (i = 0; i < 100 && cpuStall === 1'b1; i = i + 1) tick;
   lenCheck(t);
   regRead(CTL);
   chk("ctlEnd", 24'h004041, {8'h00, v});
   // master clear mid-cycle flags the abort and keeps the address
   regWrite(ADH, 16'h007F);
   regWrite(ADL, 16'hF000);
   startCycle(16'h4044);
   repeat (3) tick;
   reset(1'b0);
   regRead(CTL);
   chk("ctlAbort", 24'h002000, {8'h00, v});
   regRead(ADL);
   chk("addrKept", 24'h00F000, {8'h00, v});
   reset(1'b1);
   regRead(CTL);
   chk("ctlPowerUp", 24'h000000, {8'h00, v});
   end_of_test;
end
endmodule
`default_nettype wire
